// ### hw/amc_clk_if.sv
// clock selection signals shared between the control core and clock unit
`timescale 1ns/1ps
interface amc_clk_if;
	logic [1:0] sel;
	logic tick;
	logic pin_out;
	logic pin_oe_n;
	modport core (output sel, input tick, pin_out, pin_oe_n);
	modport unit (input sel, output tick, pin_out, pin_oe_n);
endinterface

// ### hw/amc_clk_sel.sv
// master clock source selection, pin drive and divide by two
`timescale 1ns/1ps
module amc_clk_sel
(
	// system
	input wire logic clk_sys,
	input wire logic reset,
	// sources
	input wire logic int_osc,
	input wire logic clk_pin_in,
	// to core
	amc_clk_if.unit cif
);
	import amc_pkg::*;
	logic osc_d_reg;
	logic pin_d_reg;
	logic half_reg;
	logic src_rise;
	// ************************************************
	// sampled sources and edge of selected clock
	// ************************************************
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			osc_d_reg <= 1'b0;
			pin_d_reg <= 1'b0;
		end
		else
		begin
			osc_d_reg <= int_osc;
			pin_d_reg <= clk_pin_in;
		end
	end
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			half_reg <= 1'b0;
		else if (cif.sel == AMC_CK_EXT_DIV2 && clk_pin_in && !pin_d_reg)
			half_reg <= ~half_reg;
	end
	always_comb
	begin
		unique case (cif.sel)
			AMC_CK_INT, AMC_CK_INT_OUT:
				src_rise = int_osc && !osc_d_reg;
			AMC_CK_EXT:
				src_rise = clk_pin_in && !pin_d_reg;
			AMC_CK_EXT_DIV2:
				src_rise = clk_pin_in && !pin_d_reg && half_reg;
		endcase
	end
	assign cif.tick = src_rise;
	assign cif.pin_out = (cif.sel == AMC_CK_INT_OUT) ? int_osc : 1'b0;
	assign cif.pin_oe_n = (cif.sel != AMC_CK_INT_OUT);
endmodule

// ### hw/amc_ctrl.sv
// mode control core with register port for the sigma-delta converter
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - mode 0110 runs internal gain calibration, then mode becomes idle.
// - mode 0111 runs system offset calibration, then mode becomes idle.
// - mode 1000 runs system gain calibration, then mode becomes idle.
// - duty mode alternates sequence conversion with standby per fraction bit.
// - mode 1010 converts once per sync falling pulse, idles between.
// - mode 1011 converts once per sync falling pulse, standby between.
// - clock select 00 uses internal oscillator, clock pin not driven.
// - clock select 01 uses internal oscillator and drives it on pin.
// - clock select 10 takes master clock straight from the pin.
// - clock select 11 halves a double-rate pin clock.
// - result register at address 2, read only, 16 bits, resets zero.
// - pin function control register at address 3, resets to zero.
// - idle holds filter and modulator in reset, nothing else changes.
// - fraction bit clear gives 1/4 activity, set gives 1/16.
module amc_ctrl
#(
	parameter int CAL_TICKS = 32,
	parameter int SEQ_TICKS = 8
)
(
	// system
	input wire logic clk_sys,
	input wire logic reset,
	// register port
	input wire logic [amc_pkg::AMC_AW-1:0] reg_addr,
	input wire logic [amc_pkg::AMC_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [amc_pkg::AMC_DW-1:0] reg_rdata,
	// pins
	input wire logic sync_n,
	input wire logic int_osc,
	input wire logic clk_pin_in,
	output logic clk_pin_out,
	output logic clk_pin_oe_n,
	// converter core
	input wire logic result_valid,
	input wire logic [amc_pkg::AMC_DW-1:0] result_data,
	output logic filter_reset,
	output logic conv_run,
	output logic cal_run,
	output logic [1:0] cal_kind,
	output logic low_power_hold,
	output logic power_down,
	output logic [amc_pkg::AMC_DW-1:0] pin_function
);
	import amc_pkg::*;
	localparam logic [7:0] CAL_LAST = 8'(CAL_TICKS - 1);
	localparam logic [7:0] SEQ_LAST = 8'(SEQ_TICKS - 1);

	amc_clk_if cif ();
	logic [AMC_DW-1:0] setup_reg;
	logic [AMC_DW-1:0] result_reg;
	logic [AMC_DW-1:0] pinfn_reg;
	logic [AMC_DW-1:0] rdata_reg;
	amc_state_t state_reg;
	amc_state_t state_next;
	logic [7:0] cnt_reg;
	logic [3:0] slot_reg;
	logic sync_d_reg;
	logic sync_pend_reg;
	logic cal_done;
	logic seq_done;
	logic sync_fall;
	logic [3:0] mode;
	logic frac;
	logic [1:0] cal_kind_reg;
	logic [7:0] hold_cnt_reg;
	logic slot_end;
	logic [3:0] slot_after;
	logic [AMC_DW-1:0] status_word;

	// ************************************************
	// helper functions
	// ************************************************
	function automatic logic is_cal(input logic [3:0] m);
		is_cal = (m >= AMC_M_ICAL_Z) && (m <= AMC_M_SCAL_F);
	endfunction

	function automatic logic is_sync_mode(input logic [3:0] m);
		is_sync_mode = (m == AMC_M_SEQ_IDLE) || (m == AMC_M_SEQ_HOLD);
	endfunction

	function automatic logic wr_to(input logic w,
		input logic [AMC_AW-1:0] a, input logic [AMC_AW-1:0] t);
		wr_to = w && (a == t);
	endfunction

	function automatic logic [7:0] seq_wrap(input logic [7:0] c);
		seq_wrap = (c == SEQ_LAST) ? 8'h00 : c + 8'h01;
	endfunction

	assign mode = setup_reg[AMC_F_MODE_LO +: 4];
	assign frac = setup_reg[AMC_F_FRAC];
	assign cif.sel = setup_reg[AMC_F_CLK_LO +: 2];

	// ************************************************
	// clock selection unit
	// ************************************************
	amc_clk_sel u_clk
	(
		.clk_sys(clk_sys),
		.reset(reset),
		.int_osc(int_osc),
		.clk_pin_in(clk_pin_in),
		.cif(cif)
	);
	assign clk_pin_out = cif.pin_out;
	assign clk_pin_oe_n = cif.pin_oe_n;

	// ************************************************
	// setup register: software write, hardware return to idle
	// ************************************************
	// a write in the completing cycle wins over the return to idle
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			setup_reg <= AMC_SETUP_RESET;
		else if (wr_to(reg_wr, reg_addr, AMC_ADDR_SETUP))
			setup_reg <= reg_wdata;
		else if (cal_done)
			setup_reg[AMC_F_MODE_LO +: 4] <= AMC_M_IDLE;
	end

	// ************************************************
	// pin function control register
	// ************************************************
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			pinfn_reg <= AMC_PINFN_RESET;
		else if (wr_to(reg_wr, reg_addr, AMC_ADDR_PINFN))
			pinfn_reg <= reg_wdata & AMC_PINFN_MASK;
	end
	assign pin_function = pinfn_reg;

	// ************************************************
	// conversion result
	// ************************************************
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			result_reg <= AMC_RESULT_RESET;
		else if (result_valid)
			result_reg <= result_data;
	end

	// ************************************************
	// read port: data one cycle after strobe
	// ************************************************
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			rdata_reg <= '0;
		else if (reg_rd)
		begin
			unique case (reg_addr)
				AMC_ADDR_SETUP:
					rdata_reg <= setup_reg;
				AMC_ADDR_RESULT:
					rdata_reg <= result_reg;
				AMC_ADDR_PINFN:
					rdata_reg <= pinfn_reg;
				AMC_ADDR_STATUS:
					rdata_reg <= status_word;
				default:
					rdata_reg <= '0;
			endcase
		end
		else
			rdata_reg <= '0;
	end
	assign reg_rdata = rdata_reg;

	// ************************************************
	// status word: state code in the low bits
	// ************************************************
	assign status_word = {13'h0, state_reg};

	// ************************************************
	// sync pin falling pulse capture
	// ************************************************
	assign sync_fall = sync_d_reg && !sync_n;
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			sync_d_reg <= 1'b1;
		else
			sync_d_reg <= sync_n;
	end

	// ************************************************
	// pending sync pulse: a pulse beats the clear in one cycle
	// ************************************************
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			sync_pend_reg <= 1'b0;
		else if (sync_fall && is_sync_mode(mode))
			sync_pend_reg <= 1'b1;
		else if (state_reg == AMC_ST_CONV && is_sync_mode(mode))
			sync_pend_reg <= 1'b0;
	end

	// ************************************************
	// activity counters on master clock ticks
	// ************************************************
	assign cal_done = state_reg == AMC_ST_CAL && cif.tick &&
		cnt_reg == CAL_LAST && is_cal(mode);
	assign seq_done = state_reg == AMC_ST_CONV && cif.tick &&
		cnt_reg == SEQ_LAST;
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			cnt_reg <= '0;
		else if (state_reg != state_next)
			cnt_reg <= '0;
		else if (cif.tick && (state_reg == AMC_ST_CAL ||
			state_reg == AMC_ST_CONV))
			cnt_reg <= (cnt_reg == SEQ_LAST && state_reg == AMC_ST_CONV)
				? '0 : cnt_reg + 8'h01;
	end

	// ************************************************
	// duty frame: sixteen slots of one sequence time each
	// ************************************************

	function automatic logic duty_active(input logic [3:0] s,
		input logic f);
		duty_active = f ? (s <= AMC_DUTY_S_LAST)
			: (s <= AMC_DUTY_Q_LAST);
	endfunction

	// hold state counts sequence time too, so slots advance in standby
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			hold_cnt_reg <= '0;
		else if (state_reg != AMC_ST_HOLD)
			hold_cnt_reg <= '0;
		else if (cif.tick)
			hold_cnt_reg <= seq_wrap(hold_cnt_reg);
	end
	assign slot_end = cif.tick && ((state_reg == AMC_ST_CONV &&
		cnt_reg == SEQ_LAST) || (state_reg == AMC_ST_HOLD &&
		hold_cnt_reg == SEQ_LAST));
	assign slot_after = (slot_reg == AMC_SLOT_LAST) ? '0 : slot_reg + 4'h1;

	// in duty mode the slot advances at every slot end, in standby as well; other modes hold it at zero
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			slot_reg <= '0;
		else if (mode != AMC_M_DUTY)
			slot_reg <= '0;
		else if (slot_end)
			slot_reg <= slot_after;
	end

	// ************************************************
	// calibration kind
	// ************************************************
	// registered so the kind changes together with the state
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			cal_kind_reg <= '0;
		else
			cal_kind_reg <= 2'(mode - AMC_M_ICAL_Z);
	end

	// ************************************************
	// operating state
	// ************************************************
	always_comb
	begin
		state_next = state_reg;
		unique case (mode)
			AMC_M_CONT, AMC_M_SINGLE:
				state_next = AMC_ST_CONV;
			AMC_M_STANDBY:
				state_next = AMC_ST_HOLD;
			AMC_M_PDOWN:
				state_next = (state_reg == AMC_ST_HOLD ||
					state_reg == AMC_ST_OFF) ? AMC_ST_OFF : AMC_ST_CONV;
			AMC_M_IDLE:
				state_next = AMC_ST_IDLE;
			AMC_M_ICAL_Z, AMC_M_ICAL_F, AMC_M_SCAL_Z, AMC_M_SCAL_F:
				state_next = cal_done ? AMC_ST_IDLE
					: AMC_ST_CAL;
			AMC_M_DUTY:
			begin
				if (state_reg != AMC_ST_CONV && state_reg != AMC_ST_HOLD)
					state_next = AMC_ST_CONV;
				else if (slot_end)
					state_next = duty_active(slot_after, frac)
						? AMC_ST_CONV : AMC_ST_HOLD;
			end
			AMC_M_SEQ_IDLE, AMC_M_SEQ_HOLD:
			begin
				if (state_reg == AMC_ST_CONV)
				begin
					if (seq_done)
						state_next = (mode == AMC_M_SEQ_IDLE)
							? AMC_ST_IDLE : AMC_ST_HOLD;
				end
				else if (sync_pend_reg)
					state_next = AMC_ST_CONV;
				else
					state_next = (mode == AMC_M_SEQ_IDLE)
						? AMC_ST_IDLE : AMC_ST_HOLD;
			end
			// reserved codes keep the present state
			default:
				state_next = state_reg;
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			state_reg <= AMC_ST_IDLE;
		else
			state_reg <= state_next;
	end

	// ************************************************
	// converter core controls
	// ************************************************
	// all core controls decode state flip-flops only, except cal_kind, which comes from cal_kind_reg
	assign filter_reset = state_reg == AMC_ST_IDLE;
	assign conv_run = state_reg == AMC_ST_CONV;
	assign cal_run = state_reg == AMC_ST_CAL;
	assign cal_kind = cal_kind_reg;
	assign low_power_hold = state_reg == AMC_ST_HOLD;
	assign power_down = state_reg == AMC_ST_OFF;
endmodule

// ### hw/amc_pkg.sv
// constants, register map and mode codes for the converter mode/clock control
package amc_pkg;
	localparam int AMC_AW = 4;
	localparam int AMC_DW = 16;
	// register offsets
	localparam logic [3:0] AMC_ADDR_SETUP = 4'h1;
	localparam logic [3:0] AMC_ADDR_RESULT = 4'h2;
	localparam logic [3:0] AMC_ADDR_PINFN = 4'h3;
	localparam logic [3:0] AMC_ADDR_STATUS = 4'h4;
	localparam logic [15:0] AMC_SETUP_RESET = 16'h0000;
	localparam logic [15:0] AMC_RESULT_RESET = 16'h0000;
	localparam logic [15:0] AMC_PINFN_RESET = 16'h0000;
	localparam logic [15:0] AMC_PINFN_MASK = 16'h07ff;
	// setup field layout
	localparam int AMC_F_CLK_LO = 0;
	localparam int AMC_F_MODE_LO = 2;
	localparam int AMC_F_FRAC = 6;
	// modes
	localparam logic [3:0] AMC_M_CONT = 4'h0;
	localparam logic [3:0] AMC_M_SINGLE = 4'h1;
	localparam logic [3:0] AMC_M_STANDBY = 4'h2;
	localparam logic [3:0] AMC_M_PDOWN = 4'h3;
	localparam logic [3:0] AMC_M_IDLE = 4'h4;
	localparam logic [3:0] AMC_M_ICAL_Z = 4'h5;
	localparam logic [3:0] AMC_M_ICAL_F = 4'h6;
	localparam logic [3:0] AMC_M_SCAL_Z = 4'h7;
	localparam logic [3:0] AMC_M_SCAL_F = 4'h8;
	localparam logic [3:0] AMC_M_DUTY = 4'h9;
	localparam logic [3:0] AMC_M_SEQ_IDLE = 4'ha;
	localparam logic [3:0] AMC_M_SEQ_HOLD = 4'hb;
	// clock select codes
	localparam logic [1:0] AMC_CK_INT = 2'h0;
	localparam logic [1:0] AMC_CK_INT_OUT = 2'h1;
	localparam logic [1:0] AMC_CK_EXT = 2'h2;
	localparam logic [1:0] AMC_CK_EXT_DIV2 = 2'h3;
	// duty cycle frame of 16 slots: active slots for 1/4 and 1/16
	localparam logic [3:0] AMC_DUTY_Q_LAST = 4'h3;
	localparam logic [3:0] AMC_DUTY_S_LAST = 4'h0;
	localparam logic [3:0] AMC_SLOT_LAST = 4'hf;
	typedef enum logic [2:0] {
		AMC_ST_IDLE = 3'b000,
		AMC_ST_CONV = 3'b001,
		AMC_ST_CAL = 3'b011,
		AMC_ST_HOLD = 3'b010,
		AMC_ST_OFF = 3'b110
	} amc_state_t;
	typedef enum logic [1:0] {
		AMC_CAL_IZ = 2'h0,
		AMC_CAL_IF = 2'h1,
		AMC_CAL_SZ = 2'h2,
		AMC_CAL_SF = 2'h3
	} amc_cal_t;
endpackage

// ### verif/amc_clk_src.sv
// free running oscillator and external clock pin source
`timescale 1ns/1ps
module amc_clk_src
#(
	parameter int OSC_HALF = 6,
	parameter int PIN_HALF = 4
)
(
	// system
	input wire logic clk_sys,
	input wire logic reset,
	// clock sources
	output logic int_osc,
	output logic clk_pin_in
);
	int n_osc;
	int n_pin;
	// ****
	// square waves at fixed rates
	// ****
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			n_osc <= 0;
			n_pin <= 0;
			int_osc <= 1'b0;
			clk_pin_in <= 1'b0;
		end
		else
		begin
			n_osc <= (n_osc == OSC_HALF - 1) ? 0 : n_osc + 1;
			n_pin <= (n_pin == PIN_HALF - 1) ? 0 : n_pin + 1;
			if (n_osc == OSC_HALF - 1)
				int_osc <= ~int_osc;
			if (n_pin == PIN_HALF - 1)
				clk_pin_in <= ~clk_pin_in;
		end
	end
endmodule

// ### verif/amc_ctrl_sva.sv
// port assertions for the mode and clock control
`timescale 1ns/1ps
module amc_ctrl_sva
(
	// system
	input wire logic clk_sys,
	input wire logic reset,
	// register port
	input wire logic [amc_pkg::AMC_AW-1:0] reg_addr,
	input wire logic [amc_pkg::AMC_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [amc_pkg::AMC_DW-1:0] reg_rdata,
	// pins
	input wire logic sync_n,
	input wire logic int_osc,
	input wire logic clk_pin_out,
	input wire logic clk_pin_oe_n,
	// converter core
	input wire logic result_valid,
	input wire logic [amc_pkg::AMC_DW-1:0] result_data,
	input wire logic filter_reset,
	input wire logic conv_run,
	input wire logic cal_run,
	input wire logic [1:0] cal_kind,
	input wire logic low_power_hold,
	input wire logic [amc_pkg::AMC_DW-1:0] pin_function
);
	import amc_pkg::*;
	logic [1:0] sel_sh;
	logic [1:0] ck_sh;
	logic [3:0] mode_sh;
	logic [15:0] res_sh;
	logic [3:0] wm;
	logic sw;
	assign wm = reg_wdata[5:2];
	assign sw = reg_wr && reg_addr == AMC_ADDR_SETUP;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// ****
	// shadows of software writes and results
	// ****
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			sel_sh <= 2'h0;
			mode_sh <= 4'h0;
			ck_sh <= 2'h0;
		end
		else if (sw)
		begin
			sel_sh <= reg_wdata[1:0];
			mode_sh <= wm;
			ck_sh <= wm[1:0] - 2'h1;
		end
	end
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			res_sh <= 16'h0000;
		else if (result_valid)
			res_sh <= result_data;
	end
	sequence cal_go;
		sw && wm >= 4'h5 && wm <= 4'h8;
	endsequence
	sequence wake;
		$fell(sync_n) && !conv_run;
	endsequence
	oe_ctl_a: assert property (clk_pin_oe_n == (sel_sh != 2'h1))
		else $error("clock pin enable wrong");
	pin_out_a: assert property (clk_pin_out == (sel_sh == 2'h1 && int_osc))
		else $error("clock pin level wrong");
	rd_res_a: assert property (reg_rd && reg_addr == AMC_ADDR_RESULT
		|=> reg_rdata == $past(res_sh)) else $error("result read wrong");
	pin_fn_a: assert property (reg_wr && reg_addr == AMC_ADDR_PINFN
		|=> pin_function == ($past(reg_wdata) & AMC_PINFN_MASK))
		else $error("pin function wrong");
	idle_rest_a: assert property (filter_reset
		|-> !conv_run && !cal_run && !low_power_hold) else $error("idle busy");
	cal_start_a: assert property (cal_go |-> ##[1:2] cal_run)
		else $error("calibration not started");
	cal_kind_a: assert property (cal_run |-> cal_kind == ck_sh)
		else $error("calibration kind wrong");
	cal_end_a: assert property (cal_go ##[1:2] cal_run
		|-> ##[1:400] (filter_reset && !cal_run)) else $error("no idle after cal");
	seq_idle_a: assert property (wake and filter_reset && mode_sh == 4'ha
		|-> ##[1:4] conv_run ##[1:100] filter_reset) else $error("sync idle");
	seq_hold_a: assert property (wake and low_power_hold && mode_sh == 4'hb
		|-> ##[1:4] conv_run ##[1:100] low_power_hold) else $error("sync hold");
endmodule

// ### verif/tb_top.sv
// self-checking bench for the mode and clock control
`timescale 1ns/1ps
module tb_top;
	import amc_pkg::*;
	localparam int CAL = 4;
	localparam int SEQ = 2;
	localparam int OP = 12;
	localparam int PP = 8;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic sync_n = 1'b1;
	logic result_valid = 1'b0;
	logic [15:0] result_data = 16'h0000;
	logic [15:0] reg_rdata, pin_function, v, m_res, m_pin;
	logic int_osc, clk_pin_in, clk_pin_out, clk_pin_oe_n, filter_reset;
	logic conv_run, cal_run, low_power_hold, power_down;
	logic [1:0] cal_kind;
	int n_mismatch = 0;
	int checks = 0;
	int seed = 32'hd7879d9c;
	int n, a, b, p;
	amc_ctrl #(.CAL_TICKS(CAL), .SEQ_TICKS(SEQ)) i_dut (.*);
	amc_clk_src #(.OSC_HALF(OP / 2), .PIN_HALF(PP / 2)) i_src (.*);
	initial
	begin
		forever #5 clk_sys = ~clk_sys;
	end
	// ****
	// shared tasks
	// ****
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [3:0] ad, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] ad, output logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic wait_for(ref logic s, input logic l, output int c);
		for (c = 0; c < 2000 && s !== l; c++)
		begin
			@(posedge clk_sys);
			#1;
		end
		if (s !== l)
		begin
			n_mismatch++;
			$display("Error at %0t: wait ended at %h not %h", $time, s, l);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ****
	// test sequence
	// ****
	initial
	begin
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		rd(AMC_ADDR_RESULT, v);
		chk(v, AMC_RESULT_RESET);
		rd(AMC_ADDR_PINFN, v);
		chk(v, AMC_PINFN_RESET);
		rd(4'h5, v);
		chk(v, 16'h0000);
		m_res = 16'($random(seed));
		@(posedge clk_sys);
		result_data <= m_res;
		result_valid <= 1'b1;
		@(posedge clk_sys);
		result_valid <= 1'b0;
		wr(AMC_ADDR_RESULT, ~m_res);
		rd(AMC_ADDR_RESULT, v);
		chk(v, m_res);
		m_pin = 16'($random(seed));
		wr(AMC_ADDR_PINFN, m_pin);
		rd(AMC_ADDR_PINFN, v);
		chk(v, m_pin & AMC_PINFN_MASK);
		chk(pin_function, m_pin & AMC_PINFN_MASK);
		$display("test registers done");
		for (int k = 0; k < 4; k++)
		begin
			wr(AMC_ADDR_SETUP, {10'h0, 4'(k + 5), 2'(k)});
			wait_for(cal_run, 1'b1, n);
			chk(16'(cal_kind), 16'(k));
			chk(16'(clk_pin_oe_n), 16'(k != 1));
			chk(16'(clk_pin_out), 16'(k == 1 && int_osc));
			wait_for(cal_run, 1'b0, n);
			p = (k < 2) ? OP : PP * (k - 1);
			chk(16'(n >= (CAL - 1) * p && n <= (CAL + 1) * p), 16'h1);
			rd(AMC_ADDR_SETUP, v);
			chk(v, {10'h0, AMC_M_IDLE, 2'(k)});
			chk(16'(filter_reset), 16'h1);
		end
		$display("test calibration done");
		for (int s = 0; s < 2; s++)
		begin
			wr(AMC_ADDR_SETUP, {10'h0, s ? AMC_M_SEQ_HOLD : AMC_M_SEQ_IDLE, 2'h0});
			repeat (40) @(posedge clk_sys);
			#1 chk(16'(conv_run), 16'h0);
			@(posedge clk_sys);
			sync_n <= 1'b0;
			@(posedge clk_sys);
			sync_n <= 1'b1;
			wait_for(conv_run, 1'b1, n);
			wait_for(conv_run, 1'b0, n);
			chk(16'(n >= (SEQ - 1) * OP && n <= (SEQ + 1) * OP), 16'h1);
			chk(16'({filter_reset, low_power_hold}), s ? 16'h1 : 16'h2);
		end
		$display("test sync done");
		for (int f = 0; f < 2; f++)
		begin
			wr(AMC_ADDR_SETUP, {9'h0, 1'(f), AMC_M_DUTY, 2'h0});
			wait_for(conv_run, 1'b0, n);
			wait_for(conv_run, 1'b1, n);
			a = 0;
			b = 0;
			repeat (2 * 16 * SEQ * OP)
			begin
				@(posedge clk_sys);
				#1 a += conv_run;
				b += low_power_hold;
			end
			chk(16'(a), 16'(2 * 16 * SEQ * OP / (f ? 16 : 4)));
			chk(16'(a + b), 16'(2 * 16 * SEQ * OP));
		end
		$display("test duty done");
		wr(AMC_ADDR_SETUP, {10'h0, AMC_M_STANDBY, 2'h0});
		rd(AMC_ADDR_STATUS, v);
		chk(v, 16'(AMC_ST_HOLD));
		wr(AMC_ADDR_SETUP, {10'h0, AMC_M_PDOWN, 2'h0});
		rd(AMC_ADDR_STATUS, v);
		chk(v, 16'(AMC_ST_OFF));
		chk(16'(power_down), 16'h1);
		wr(AMC_ADDR_SETUP, {10'h0, AMC_M_CONT, 2'h0});
		wr(AMC_ADDR_SETUP, {10'h0, AMC_M_PDOWN, 2'h0});
		rd(AMC_ADDR_STATUS, v);
		chk(v, 16'(AMC_ST_CONV));
		chk(16'({conv_run, power_down}), 16'h2);
		$display("test power modes done");
		report_and_stop();
	end
	initial
	begin
		#300000;
		n_mismatch++;
		report_and_stop();
	end
endmodule
bind amc_ctrl amc_ctrl_sva u_sva (.*);
